// *** hdl/rmt_dev.sv ***
`timescale 1ns/1ns
`include "rmt_map.svh"
module rmt_dev #(
   parameter int INIT1_CYC = `RMT_INIT1_CYC,
   parameter int INIT2_CYC = `RMT_INIT2_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // two-wire link
   rmt_link_if.dev link,
   // pins and converter
   input wire logic tx_disable_pin,
   input wire logic rx_disable_pin,
   input wire logic [9:0] adc_sample,
   input wire logic adc_sample_valid,
   // status
   output logic chip_ready,
   output logic bias_current_off,
   output logic converter_run,
   output logic [2:0] monitor_channel_select,
   // receive path controls
   output logic rx_equalizer_bypass,
   output logic [2:0] rx_equalizer_amount,
   output logic rx_offset_cancel_off,
   output logic [3:0] rx_threshold_adjust,
   output logic rx_output_invert,
   output logic rx_driver_off,
   output logic rx_path_powerdown,
   output logic [3:0] rx_output_amplitude,
   output logic [2:0] rx_output_deemphasis,
   output logic optical_loopback_sel,
   output logic signal_loss_range,
   output logic [5:0] signal_loss_assert_level,
   output logic signal_loss_hyst_reduce,
   output logic signal_loss_fast
);
   // ---------------------------------------------
   // pin synchronisers
   // ---------------------------------------------
   logic [1:0] scl_s_q, sda_s_q, txd_s_q, rxd_s_q;
   logic scl_p_q, sda_p_q;
   logic scl_i, sda_i, rise, fall, start, stop;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         txd_s_q <= 2'h0;
         rxd_s_q <= 2'h0;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], link.scl};
         sda_s_q <= {sda_s_q[0], link.sda};
         txd_s_q <= {txd_s_q[0], tx_disable_pin};
         rxd_s_q <= {rxd_s_q[0], rx_disable_pin};
         scl_p_q <= scl_s_q[1];
         sda_p_q <= sda_s_q[1];
      end
   end
   assign scl_i = scl_s_q[1];
   assign sda_i = sda_s_q[1];
   assign rise = scl_i & ~scl_p_q;
   assign fall = ~scl_i & scl_p_q;
   assign start = scl_i & scl_p_q & sda_p_q & ~sda_i;
   assign stop = scl_i & scl_p_q & ~sda_p_q & sda_i;
   // ---------------------------------------------
   // init timers
   // ---------------------------------------------
   logic [15:0] init_cnt_q;
   logic glob_q, regrst_q, loads_ok, chip_ready_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || glob_q) begin
         init_cnt_q <= 16'h0000;
      end else if (init_cnt_q < 16'(INIT2_CYC)) begin
         init_cnt_q <= init_cnt_q + 16'h0001;
      end
   end
   assign loads_ok = init_cnt_q >= 16'(INIT1_CYC);
   // ---------------------------------------------
   // registers
   // ---------------------------------------------
   logic [7:0] core_q, loop_q, mon_q, rxp_q, eq_q, th_q, los_q, amp_q, bmon_q;
   logic [9:0] adc_q;
   logic [7:0] ptr_q, sh_q, rd_data;
   logic wr_q, run_q, chan_ok;
   always_comb begin
      case (ptr_q)
         `RMT_OFS_CORE: rd_data = core_q & 8'h7D;
         `RMT_OFS_LOOP: rd_data = loop_q;
         `RMT_OFS_MON: rd_data = mon_q;
         `RMT_OFS_RXP: rd_data = rxp_q;
         `RMT_OFS_EQ: rd_data = eq_q;
         `RMT_OFS_TH: rd_data = th_q;
         `RMT_OFS_LOS: rd_data = los_q;
         `RMT_OFS_AMP: rd_data = amp_q;
         `RMT_OFS_BMON: rd_data = bmon_q;
         `RMT_OFS_RES_HI: rd_data = adc_q[9:2];
         `RMT_OFS_RES_LO: rd_data = {6'h00, adc_q[1:0]};
         default: rd_data = 8'h00;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || glob_q || regrst_q) begin
         core_q <= `RMT_RST_CORE;
         loop_q <= `RMT_RST_ZERO;
         mon_q <= `RMT_RST_ZERO;
         rxp_q <= `RMT_RST_ZERO;
         eq_q <= `RMT_RST_ZERO;
         th_q <= `RMT_RST_ZERO;
         los_q <= `RMT_RST_ZERO;
         amp_q <= `RMT_RST_ZERO;
         bmon_q <= `RMT_RST_ZERO;
      end else if (wr_q) begin
         case (ptr_q)
            `RMT_OFS_CORE: core_q <= sh_q;
            `RMT_OFS_LOOP: loop_q <= sh_q;
            `RMT_OFS_MON: mon_q <= sh_q;
            `RMT_OFS_RXP: rxp_q <= sh_q;
            `RMT_OFS_EQ: eq_q <= sh_q;
            `RMT_OFS_TH: th_q <= sh_q;
            `RMT_OFS_LOS: los_q <= sh_q;
            `RMT_OFS_AMP: amp_q <= sh_q;
            `RMT_OFS_BMON: bmon_q <= sh_q;
            default: core_q <= core_q;
         endcase
      end
   end
   // self-clearing reset strobes act one cycle after the write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         glob_q <= 1'b0;
         regrst_q <= 1'b0;
      end else begin
         glob_q <= wr_q && ptr_q == `RMT_OFS_CORE && sh_q[`RMT_CORE_GLBRST];
         regrst_q <= wr_q && ptr_q == `RMT_OFS_CORE && sh_q[`RMT_CORE_REGRST];
      end
   end
   // ---------------------------------------------
   // monitor converter capture
   // ---------------------------------------------
   always_comb begin
      case (mon_q[2:0])
         `RMT_CH_TEMP: chan_ok = 1'b1;
         `RMT_CH_SUPPLY: chan_ok = 1'b1;
         `RMT_CH_BIAS: chan_ok = bmon_q[`RMT_BMON_BIAS];
         `RMT_CH_PD: chan_ok = bmon_q[`RMT_BMON_PD];
         default: chan_ok = 1'b0;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || glob_q) begin
         adc_q <= 10'h000;
         run_q <= 1'b0;
         chip_ready_q <= 1'b0;
      end else begin
         run_q <= mon_q[`RMT_MON_OSC] & mon_q[`RMT_MON_ADC];
         if (run_q && adc_sample_valid && chan_ok) begin
            adc_q <= adc_sample;
         end
         chip_ready_q <= init_cnt_q >= 16'(INIT2_CYC) && core_q[`RMT_CORE_EN] && !txd_s_q[1]
            && !rxd_s_q[1];
      end
   end
   // ---------------------------------------------
   // two-wire slave
   // ---------------------------------------------
   rmt_pkg::rmt_dev_st_t st_q;
   logic [3:0] cnt_q;
   logic rw_q, pull_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= rmt_pkg::RMT_D_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         rw_q <= 1'b0;
         ptr_q <= 8'h00;
         pull_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         wr_q <= 1'b0;
         if (start) begin
            st_q <= rmt_pkg::RMT_D_ADDR;
            cnt_q <= 4'h0;
            pull_q <= 1'b0;
         end else if (stop) begin
            st_q <= rmt_pkg::RMT_D_IDLE;
            pull_q <= 1'b0;
         end else if (rise) begin
            if (st_q == rmt_pkg::RMT_D_ADDR || st_q == rmt_pkg::RMT_D_REG || st_q == rmt_pkg::RMT_D_WDAT) begin
               sh_q <= {sh_q[6:0], sda_i};
               cnt_q <= cnt_q + 4'h1;
            end else if (st_q == rmt_pkg::RMT_D_RDAT) begin
               cnt_q <= cnt_q + 4'h1;
            end
         end else if (fall) begin
            case (st_q)
               rmt_pkg::RMT_D_ADDR: if (cnt_q == 4'h8) begin
                  if (sh_q[7:1] == `RMT_DEV_ADDR) begin
                     st_q <= rmt_pkg::RMT_D_AACK;
                     pull_q <= 1'b1;
                     rw_q <= sh_q[0] == `RMT_DIR_READ;
                  end else begin
                     st_q <= rmt_pkg::RMT_D_DONE;
                  end
               end
               rmt_pkg::RMT_D_AACK: begin
                  st_q <= rmt_pkg::RMT_D_REG;
                  cnt_q <= 4'h0;
                  pull_q <= 1'b0;
               end
               rmt_pkg::RMT_D_REG: if (cnt_q == 4'h8) begin
                  ptr_q <= sh_q;
                  st_q <= rmt_pkg::RMT_D_RACK;
                  pull_q <= 1'b1;
               end
               rmt_pkg::RMT_D_RACK: begin
                  cnt_q <= 4'h0;
                  if (rw_q) begin
                     st_q <= rmt_pkg::RMT_D_RDAT;
                     sh_q <= rd_data;
                     pull_q <= ~rd_data[7];
                  end else begin
                     st_q <= rmt_pkg::RMT_D_WDAT;
                     pull_q <= 1'b0;
                  end
               end
               rmt_pkg::RMT_D_WDAT: if (cnt_q == 4'h8) begin
                  if (loads_ok) begin
                     st_q <= rmt_pkg::RMT_D_WACK;
                     pull_q <= 1'b1;
                     wr_q <= 1'b1;
                  end else begin
                     st_q <= rmt_pkg::RMT_D_DONE;
                  end
               end
               rmt_pkg::RMT_D_WACK: begin
                  st_q <= rmt_pkg::RMT_D_DONE;
                  pull_q <= 1'b0;
               end
               rmt_pkg::RMT_D_RDAT: if (cnt_q == 4'h8) begin
                  st_q <= rmt_pkg::RMT_D_DONE;
                  pull_q <= 1'b0;
               end else begin
                  sh_q <= {sh_q[6:0], 1'b0};
                  pull_q <= ~sh_q[6];
               end
               default: pull_q <= 1'b0;
            endcase
         end
      end
   end
   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe_n = ~pull_q;
   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   assign chip_ready = chip_ready_q;
   assign bias_current_off = txd_s_q[1];
   assign converter_run = run_q;
   assign monitor_channel_select = mon_q[2:0];
   assign rx_equalizer_bypass = rxp_q[1];
   assign rx_equalizer_amount = eq_q[2:0];
   assign rx_offset_cancel_off = rxp_q[2];
   // threshold forced to zero while offset cancel is off, the trim has no meaning then
   assign rx_threshold_adjust = rxp_q[2] ? 4'h0 : th_q[3:0];
   assign rx_output_invert = rxp_q[5];
   assign rx_driver_off = rxp_q[6];
   assign rx_path_powerdown = rxp_q[7];
   assign rx_output_amplitude = amp_q[3:0];
   assign rx_output_deemphasis = amp_q[6:4];
   assign optical_loopback_sel = loop_q[1];
   assign signal_loss_range = rxp_q[0];
   assign signal_loss_assert_level = los_q[5:0];
   assign signal_loss_hyst_reduce = th_q[7];
   assign signal_loss_fast = eq_q[3];
endmodule : rmt_dev

// *** pkg/rmt_map.svh ***
`ifndef RMT_MAP_SVH
`define RMT_MAP_SVH
// ---------------------------------------------
// link addressing
// ---------------------------------------------
`define RMT_DEV_ADDR 7'h08
`define RMT_DIR_READ 1'b1
// ---------------------------------------------
// device register offsets
// ---------------------------------------------
`define RMT_OFS_CORE 8'h00
`define RMT_OFS_LOOP 8'h02
`define RMT_OFS_MON 8'h03
`define RMT_OFS_RXP 8'h04
`define RMT_OFS_EQ 8'h05
`define RMT_OFS_TH 8'h06
`define RMT_OFS_LOS 8'h07
`define RMT_OFS_AMP 8'h08
`define RMT_OFS_BMON 8'h10
`define RMT_OFS_RES_HI 8'h28
`define RMT_OFS_RES_LO 8'h29
// ---------------------------------------------
// reset values and field positions
// ---------------------------------------------
`define RMT_RST_CORE 8'h41
`define RMT_RST_ZERO 8'h00
`define RMT_CORE_EN 0
`define RMT_CORE_REGRST 1
`define RMT_CORE_GLBRST 7
`define RMT_MON_OSC 6
`define RMT_MON_ADC 7
`define RMT_BMON_BIAS 5
`define RMT_BMON_PD 6
`define RMT_CH_TEMP 3'h0
`define RMT_CH_SUPPLY 3'h1
`define RMT_CH_BIAS 3'h2
`define RMT_CH_PD 3'h3
// ---------------------------------------------
// timing
// ---------------------------------------------
`define RMT_CLK_MHZ 50
`define RMT_POWER_ON_INIT_TIME_NS 1000
`define RMT_INIT_TO_TRANSMIT_TIME_NS 2000
`define RMT_INIT1_CYC ((`RMT_POWER_ON_INIT_TIME_NS * `RMT_CLK_MHZ + 999) / 1000)
`define RMT_INIT2_CYC ((`RMT_INIT_TO_TRANSMIT_TIME_NS * `RMT_CLK_MHZ + 999) / 1000)
`define RMT_HOST_QUARTER 5
// ---------------------------------------------
// host register map (axi4-lite)
// ---------------------------------------------
`define RMT_HOFS_CMD 4'h0
`define RMT_HOFS_STAT 4'h4
`define RMT_RESP_OKAY 2'h0
`define RMT_RESP_SLVERR 2'h2
`endif

// *** pkg/rmt_pkg.sv ***
package rmt_pkg;
   typedef enum logic [3:0] {
      RMT_D_IDLE = 4'h0,
      RMT_D_ADDR = 4'h1,
      RMT_D_AACK = 4'h3,
      RMT_D_REG = 4'h2,
      RMT_D_RACK = 4'h6,
      RMT_D_WDAT = 4'h7,
      RMT_D_WACK = 4'h5,
      RMT_D_RDAT = 4'h4,
      RMT_D_DONE = 4'hC
   } rmt_dev_st_t;
   typedef enum logic [1:0] {
      RMT_H_IDLE = 2'h0,
      RMT_H_START = 2'h1,
      RMT_H_BIT = 2'h3,
      RMT_H_STOP = 2'h2
   } rmt_host_st_t;
endpackage : rmt_pkg

// *** pkg/rmt_link_if.sv ***
`timescale 1ns/1ns
interface rmt_link_if;
   logic host_scl_o;
   logic host_scl_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic scl;
   logic sda;
   // open drain with pull-up: released lines read high
   assign scl = host_scl_oe_n | host_scl_o;
   assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
   modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n, output host_sda_o,
      output host_sda_oe_n);
endinterface : rmt_link_if

// *** hdl/rmt_host.sv ***
`timescale 1ns/1ns
`include "rmt_map.svh"
module rmt_host #(
   parameter int QUARTER = `RMT_HOST_QUARTER
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // two-wire link
   rmt_link_if.host link
);
   // ---------------------------------------------
   // axi4-lite slave
   // ---------------------------------------------
   logic aw_q, w_q, bv_q, rv_q, busy_q, nack_q, go;
   logic [3:0] awa_q;
   logic [31:0] wd_q, cmd_q, rd_q;
   logic [3:0] ws_q;
   logic [1:0] br_q, rr_q;
   logic [7:0] rx_q;
   assign s_axi_awready = ~aw_q & ~bv_q;
   assign s_axi_wready = ~w_q & ~bv_q;
   assign go = aw_q && w_q && !bv_q && awa_q == `RMT_HOFS_CMD && ws_q == 4'hF && wd_q[0] && !busy_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         bv_q <= 1'b0;
         awa_q <= 4'h0;
         wd_q <= 32'h0;
         ws_q <= 4'h0;
         br_q <= `RMT_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awa_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (aw_q && w_q && !bv_q) begin
            bv_q <= 1'b1;
            aw_q <= 1'b0;
            w_q <= 1'b0;
            br_q <= (awa_q == `RMT_HOFS_CMD || awa_q == `RMT_HOFS_STAT) ? `RMT_RESP_OKAY : `RMT_RESP_SLVERR;
         end else if (bv_q && s_axi_bready) begin
            bv_q <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_arready = ~rv_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rv_q <= 1'b0;
         rd_q <= 32'h0;
         rr_q <= `RMT_RESP_OKAY;
      end else if (s_axi_arvalid && !rv_q) begin
         rv_q <= 1'b1;
         rr_q <= `RMT_RESP_OKAY;
         case (s_axi_araddr)
            `RMT_HOFS_CMD: rd_q <= cmd_q;
            `RMT_HOFS_STAT: rd_q <= {16'h0000, rx_q, 6'h00, nack_q, busy_q};
            default: begin
               rd_q <= 32'h0;
               rr_q <= `RMT_RESP_SLVERR;
            end
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;
   // ---------------------------------------------
   // two-wire master
   // ---------------------------------------------
   rmt_pkg::rmt_host_st_t st_q;
   logic [15:0] div_q;
   logic [1:0] ph_q, byte_q;
   logic [3:0] bit_q;
   logic [7:0] tx_q;
   logic [1:0] sda_s_q;
   logic scl_q, rel_q, tick, rd_phase;
   assign tick = div_q == 16'(QUARTER - 1);
   assign rd_phase = cmd_q[1] && byte_q == 2'h2;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sda_s_q <= 2'h3;
         div_q <= 16'h0000;
      end else begin
         sda_s_q <= {sda_s_q[0], link.sda};
         div_q <= (tick || st_q == rmt_pkg::RMT_H_IDLE) ? 16'h0000 : div_q + 16'h0001;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= rmt_pkg::RMT_H_IDLE;
         ph_q <= 2'h0;
         byte_q <= 2'h0;
         bit_q <= 4'h0;
         tx_q <= 8'h00;
         rx_q <= 8'h00;
         cmd_q <= 32'h0;
         scl_q <= 1'b1;
         rel_q <= 1'b1;
         busy_q <= 1'b0;
         nack_q <= 1'b0;
      end else if (st_q == rmt_pkg::RMT_H_IDLE) begin
         if (go) begin
            cmd_q <= wd_q;
            busy_q <= 1'b1;
            nack_q <= 1'b0;
            st_q <= rmt_pkg::RMT_H_START;
            ph_q <= 2'h0;
         end
      end else if (tick) begin
         ph_q <= ph_q + 2'h1;
         case (st_q)
            rmt_pkg::RMT_H_START: begin
               if (ph_q == 2'h0) begin
                  rel_q <= 1'b0;
               end else begin
                  scl_q <= 1'b0;
                  st_q <= rmt_pkg::RMT_H_BIT;
                  ph_q <= 2'h0;
                  byte_q <= 2'h0;
                  bit_q <= 4'h0;
                  tx_q <= {`RMT_DEV_ADDR, cmd_q[1]};
               end
            end
            rmt_pkg::RMT_H_BIT: case (ph_q)
               2'h0: rel_q <= (bit_q == 4'h8 || rd_phase) ? 1'b1 : tx_q[7];
               2'h1: scl_q <= 1'b1;
               2'h2: if (bit_q != 4'h8) begin
                  tx_q <= {tx_q[6:0], 1'b0};
                  if (rd_phase) begin
                     rx_q <= {rx_q[6:0], sda_s_q[1]};
                  end
               end else if (!rd_phase && sda_s_q[1]) begin
                  nack_q <= 1'b1;
               end
               default: begin
                  scl_q <= 1'b0;
                  if (bit_q != 4'h8) begin
                     bit_q <= bit_q + 4'h1;
                  end else if (byte_q == 2'h2 || nack_q) begin
                     st_q <= rmt_pkg::RMT_H_STOP;
                  end else begin
                     byte_q <= byte_q + 2'h1;
                     bit_q <= 4'h0;
                     tx_q <= byte_q == 2'h0 ? cmd_q[15:8] : cmd_q[23:16];
                  end
               end
            endcase
            default: case (ph_q)
               2'h0: rel_q <= 1'b0;
               2'h1: scl_q <= 1'b1;
               2'h2: rel_q <= 1'b1;
               default: begin
                  st_q <= rmt_pkg::RMT_H_IDLE;
                  busy_q <= 1'b0;
               end
            endcase
         endcase
      end
   end
   assign link.host_scl_o = 1'b0;
   assign link.host_scl_oe_n = scl_q;
   assign link.host_sda_o = 1'b0;
   assign link.host_sda_oe_n = rel_q;
endmodule : rmt_host

// *** verif/rmt_asserts.sv ***
`timescale 1ns/1ns
module rmt_asserts (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // link
   input wire logic host_scl_o,
   input wire logic host_sda_o,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe_n,
   input wire logic scl,
   input wire logic sda
);
   // ----
   // bit count since start
   // ----
   logic scl_q;
   logic sda_q;
   logic [4:0] cnt_q;
   wire st = scl && scl_q && sda_q && !sda;
   wire sp = scl && scl_q && !sda_q && sda;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk) begin
      scl_q <= scl;
      sda_q <= sda;
      if (!aresetn || st) begin
         cnt_q <= 5'h00;
      end else if (scl && !scl_q && cnt_q != 5'h1F) begin
         cnt_q <= cnt_q + 5'h01;
      end
   end
   // ----
   // checks
   // ----
   drive_zero_a: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
      else $error("link driven high");
   ack_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
      else $error("device data moved while clock high");
   ack_slot_a: assert property (scl && scl_q && !dev_sda_oe_n |-> cnt_q inside {5'h09, [5'h12:5'h1B]})
      else $error("device drives outside its slots");
   addr_ack_a: assert property (scl && scl_q && cnt_q == 5'h09 |-> !sda)
      else $error("address not acknowledged");
   start_clk_a: assert property (st |-> ##[1:12] !scl)
      else $error("no clock after start");
   stop_idle_a: assert property (sp |=> (scl && sda) [*4])
      else $error("bus not idle after stop");
   stop_free_a: assert property (sp |-> dev_sda_oe_n)
      else $error("device holds data at stop");
   high_len_a: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high too short");
   low_len_a: assert property ($fell(scl) |-> !scl [*4] ##[1:8] scl)
      else $error("clock low phase wrong");
   one_byte_a: assert property ($rose(scl) |-> cnt_q <= 5'h1B)
      else $error("more than one data byte");
   cover property (st);
   cover property (sp);
   cover property (scl && !dev_sda_oe_n && cnt_q == 5'h1B);
endmodule : rmt_asserts

// *** verif/rmt_tb_top.sv ***
`timescale 1ns/1ns
`include "rmt_map.svh"
module rmt_tb_top;
   // ----
   // signals and model
   // ----
   logic aclk, aresetn, tx_disable_pin, rx_disable_pin, adc_sample_valid;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [3:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
   logic [9:0] adc_sample, res;
   logic chip_ready, bias_current_off, converter_run, rx_equalizer_bypass, rx_offset_cancel_off;
   logic rx_output_invert, rx_driver_off, rx_path_powerdown, optical_loopback_sel, signal_loss_range;
   logic signal_loss_hyst_reduce, signal_loss_fast;
   logic [2:0] monitor_channel_select, rx_equalizer_amount, rx_output_deemphasis;
   logic [3:0] rx_threshold_adjust, rx_output_amplitude;
   logic [5:0] signal_loss_assert_level;
   logic [7:0] m [256];
   logic [7:0] map [11] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h10, 8'h28, 8'h29};
   logic [7:0] ac [7] = '{8'h40, 8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC3, 8'hC4};
   int failures, total_checks;
   rmt_link_if link ();
   rmt_dev #(.INIT1_CYC(4), .INIT2_CYC(8)) rmt_dev_inst (.aclk, .aresetn, .link(link.dev), .tx_disable_pin,
      .rx_disable_pin, .adc_sample, .adc_sample_valid, .chip_ready, .bias_current_off, .converter_run,
      .monitor_channel_select, .rx_equalizer_bypass, .rx_equalizer_amount, .rx_offset_cancel_off,
      .rx_threshold_adjust, .rx_output_invert, .rx_driver_off, .rx_path_powerdown, .rx_output_amplitude,
      .rx_output_deemphasis, .optical_loopback_sel, .signal_loss_range, .signal_loss_assert_level,
      .signal_loss_hyst_reduce, .signal_loss_fast);
   rmt_host rmt_host_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .link(link.host));
   rmt_asserts rmt_asserts_inst (.aclk, .aresetn, .host_scl_o(link.host_scl_o), .host_sda_o(link.host_sda_o),
      .dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n), .scl(link.scl), .sda(link.sda));
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // ----
   // tasks
   // ----
   task automatic summarize();
      if (failures == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %0t %h %h", $time, s, e);
      end
   endtask : chk
   // bounded waits: a hung link must not stall the run
   task automatic to(inout int n);
      n++;
      if (n > 3000) begin
         failures++;
         summarize();
      end
   endtask : to
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      logic aw_ok, w_ok, b_ok;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         // mid-cycle sample: what the next rising edge sees, no race with it
         @(negedge aclk);
         aw_ok = s_axi_awvalid & s_axi_awready;
         w_ok = s_axi_wvalid & s_axi_wready;
         b_ok = s_axi_bvalid;
         if (b_ok) br = s_axi_bresp;
         @(posedge aclk);
         if (aw_ok) s_axi_awvalid <= 1'b0;
         if (w_ok) s_axi_wvalid <= 1'b0;
         to(n);
      end while (!b_ok);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      int n;
      logic ar_ok, r_ok;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(negedge aclk);
         ar_ok = s_axi_arvalid & s_axi_arready;
         r_ok = s_axi_rvalid;
         if (r_ok) {rv, rr} = {s_axi_rdata, s_axi_rresp};
         @(posedge aclk);
         if (ar_ok) s_axi_arvalid <= 1'b0;
         to(n);
      end while (!r_ok);
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic op(input logic r, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      wr(`RMT_HOFS_CMD, {8'h00, d, a, 6'h00, r, 1'b1});
      chk(br, `RMT_RESP_OKAY);
      do begin
         rd(`RMT_HOFS_STAT);
         to(n);
      end while (rv[0] !== 1'b0);
   endtask : op
   function automatic void dflt(input logic g);
      foreach (m[i]) m[i] = 8'h00;
      m[0] = 8'h41;
      if (g) res = 10'h000;
   endfunction : dflt
   task automatic mw(input logic [7:0] a, input logic [7:0] d);
      op(1'b0, a, d);
      chk(rv[1], 1'b0);
      if (a == `RMT_OFS_CORE && (d[1] || d[7])) dflt(d[7]);
      else m[a] = d;
   endtask : mw
   task automatic mr(input logic [7:0] a);
      op(1'b1, a, 8'h00);
      chk(rv[15:8], a == 8'h00 ? m[0] & 8'h7D : a == 8'h28 ? res[9:2] : a == 8'h29 ? {6'h00, res[1:0]} : m[a]);
   endtask : mr
   task automatic outs();
      chk({rx_equalizer_bypass, rx_equalizer_amount, rx_offset_cancel_off, rx_threshold_adjust, rx_output_invert,
         rx_driver_off, rx_path_powerdown, rx_output_amplitude, rx_output_deemphasis}, {m[4][1], m[5][2:0], m[4][2],
         m[4][2] ? 4'h0 : m[6][3:0], m[4][5], m[4][6], m[4][7], m[8][3:0], m[8][6:4]});
      chk({optical_loopback_sel, signal_loss_range, signal_loss_assert_level, signal_loss_hyst_reduce,
         signal_loss_fast, monitor_channel_select, converter_run}, {m[2][1], m[4][0], m[7][5:0], m[6][7], m[5][3],
         m[3][2:0], m[3][7] & m[3][6]});
   endtask : outs
   // ----
   // sequence
   // ----
   initial begin
      {aresetn, tx_disable_pin, rx_disable_pin, adc_sample_valid, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, adc_sample, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      failures = 0;
      total_checks = 0;
      rv = $urandom(34220);
      dflt(1'b1);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (20) @(posedge aclk);
      chk(chip_ready, 1'b1);
      foreach (map[i]) mr(map[i]);
      for (int i = 1; i < 9; i++) mw(map[i], 8'($urandom));
      outs();
      foreach (map[i]) mr(map[i]);
      {tx_disable_pin, rx_disable_pin} <= 2'h3;
      repeat (8) @(posedge aclk);
      chk({bias_current_off, chip_ready}, 2'h2);
      outs();
      {tx_disable_pin, rx_disable_pin} <= 2'h0;
      mw(`RMT_OFS_BMON, 8'h20);
      foreach (ac[i]) begin
         if (i == 5) mw(`RMT_OFS_BMON, 8'h40);
         mw(`RMT_OFS_MON, ac[i]);
         adc_sample <= 10'($urandom);
         adc_sample_valid <= 1'b1;
         @(posedge aclk);
         adc_sample_valid <= 1'b0;
         if (i inside {[1:3], 5}) res = adc_sample;
         mr(`RMT_OFS_RES_HI);
         mr(`RMT_OFS_RES_LO);
      end
      mw(`RMT_OFS_CORE, 8'h02);
      foreach (map[i]) mr(map[i]);
      mw(`RMT_OFS_CORE, 8'h80);
      foreach (map[i]) mr(map[i]);
      rd(4'h8);
      chk(rr, `RMT_RESP_SLVERR);
      wr(4'h8, 32'h00000001);
      chk(br, `RMT_RESP_SLVERR);
      summarize();
   end
endmodule : rmt_tb_top
